// File: include/stndc_pkg.sv
// Purpose: Shared constants and types for the STN display control block.
// Assumes: 40 MHz pclk, APB register access with 32-bit data.
// Notes:   Times are kept in their own unit; line and wake times are turned into cycles here, rail settle time in stndc_top.
`default_nettype none
package stndc_pkg;
    localparam int CLK_NS = 25;

    // Register byte offsets.
    localparam logic [11:0] OFS_LINE_CTRL = 12'h000;
    localparam logic [11:0] OFS_DISP_CTRL = 12'h004;
    localparam logic [11:0] OFS_LAST_COM  = 12'h008;
    localparam logic [11:0] OFS_ACT_FIRST = 12'h00c;
    localparam logic [11:0] OFS_ACT_LAST  = 12'h010;
    localparam logic [11:0] OFS_SCROLL    = 12'h014;
    localparam logic [11:0] OFS_FIXED     = 12'h018;
    localparam logic [11:0] OFS_COLOR_FMT = 12'h01c;
    localparam logic [11:0] OFS_STATUS    = 12'h020;

    // Field positions.
    localparam int LC_RATE_LSB   = 3;
    localparam int LC_SHADE8_BIT = 5;
    localparam int LC_ONOFF_BIT  = 8;
    localparam int LC_PART_BIT   = 9;
    localparam int DC_DRV_BIT    = 2;
    localparam int DC_ALLON_BIT  = 1;
    localparam int DC_INV_BIT    = 0;

    // Values after reset.
    localparam logic [9:0] LC_RST        = 10'h000;
    localparam logic [2:0] DC_RST        = 3'h0;
    localparam logic [6:0] LAST_COM_RST  = 7'h4f;
    localparam logic [6:0] ACT_FIRST_RST = 7'h00;
    localparam logic [6:0] ACT_LAST_RST  = 7'h4f;
    localparam logic [6:0] ROWREG_RST    = 7'h00;

    // Multiplex thresholds for automatic line rate slowdown.
    localparam logic [7:0] MUX_HALF  = 8'h26;
    localparam logic [7:0] MUX_THIRD = 8'h18;
    localparam logic [6:0] ROWS_LAST = 7'h4f;

    // Base line periods in ns for the four line rate codes.
    localparam int LINE0_NS = 40000;
    localparam int LINE1_NS = 34000;
    localparam int LINE2_NS = 29000;
    localparam int LINE3_NS = 25000;
    localparam logic [10:0] LINE0_CYC = 11'((LINE0_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [10:0] LINE1_CYC = 11'((LINE1_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [10:0] LINE2_CYC = 11'((LINE2_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [10:0] LINE3_CYC = 11'((LINE3_NS + CLK_NS - 1) / CLK_NS);

    // 8-shade stretch of the line period: 10/7 gives a rate about 30 % lower.
    localparam logic [3:0] SH8_NUM = 4'ha;
    localparam logic [3:0] SH8_DEN = 4'h7;

    // Power-up sequencing times.
    localparam int WAKE_NS        = 1000;
    localparam int WAKE_CYC       = (WAKE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RAIL_SETTLE_US = 2000;

    typedef enum logic [1:0] {
        PWR_SLEEP  = 2'b00,
        PWR_WAKE   = 2'b01,
        PWR_RAILS  = 2'b11,
        PWR_ACTIVE = 2'b10
    } stndc_pwr_t;

    typedef enum logic [1:0] {
        FMT_8BIT  = 2'b00,
        FMT_12BIT = 2'b01,
        FMT_16BIT = 2'b10,
        FMT_24BIT = 2'b11
    } stndc_fmt_t;

    localparam stndc_fmt_t FMT_RST = FMT_16BIT;
endpackage : stndc_pkg
`default_nettype wire

// File: logic/stndc_top.sv
// Purpose: Line and frame timing, driver sequencing, segment overrides,
//          fixed-region scrolling and input color conversion of an STN panel.
// Assumes: pclk stands in for the built-in oscillator; display RAM is outside.
// Notes:   APB answers with no wait state; unmapped offsets give pslverr.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Two-bit line rate field picks one of four line periods for each COM slot.
// - Above multiplex 38 a frame lasts multiplex-rate line periods.
// - At multiplex 38 or below the line period doubles; at 24 or below it triples.
// - In 8-shade mode the line period stretches by 10/7, about 30 % slower.
// - Clearing display enable idles COM and SEG drivers and enters sleep.
// - Setting enable raises the flag, leaves sleep, restores rails, then drives.
// - Idle segment drivers are shorted together to keep the panel free of DC.
// - Display control holds drivers-on, force-all-on and invert; drivers-on dominates.
// - Force-all-on drives every segment to ON without touching RAM.
// - Force-all-on does nothing while drivers-on is clear.
// - Invert outputs the bitwise inverse of RAM data without touching RAM.
// - Rows in the fixed region ignore the scroll offset; the rest scroll.
// - COM driver x always drives panel row x, whatever the other settings.
// - Two modulation schemes, 32-shade and low-power 8-shade, are selectable.
// - Switching modulation leaves display RAM untouched.
// - 8-bit pixels are expanded to the RAM pixel format before storing.
// - 12-bit pixels get green extended and blue dithered to 4R-5G-3B.
// - 16-bit input is the reset default and is dithered to 12-bit pixels.
// - 24-bit pixels are dithered to 4R-5G-3B.
// - Changing input format leaves stored RAM data untouched.
// - Gray partial mode keeps all slots but suppresses pulses outside the window.
// - On-off partial mode scans only rows from window start to window end.
module stndc_top
    import stndc_pkg::*;
#(
    parameter int NUM_COM  = 80,
    parameter int SEG_W    = 12,
    parameter int RAIL_CYC = RAIL_SETTLE_US * 1000 / CLK_NS
) (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Host pixel stream in
    input  wire logic               pix_valid,
    output logic                    pix_ready,
    input  wire logic [23:0]        pix_data,
    input  wire logic [6:0]         pix_col,
    input  wire logic [6:0]         pix_row,
    // Converted pixel toward display RAM
    output logic                    ram_wr_valid,
    input  wire logic               ram_wr_ready,
    output logic      [11:0]        ram_wr_data,
    // Display RAM scan read
    output logic      [6:0]         ram_rd_row,
    input  wire logic [SEG_W-1:0]   ram_rd_data,
    // Panel drive
    output logic      [NUM_COM-1:0] com_drive,
    output logic      [SEG_W-1:0]   seg_out,
    output logic                    seg_short,
    output logic                    shade8_active,
    output logic                    frame_start,
    // Power control
    output logic                    lcd_sleep,
    output logic                    lcd_rails_on
);
    import stndc_pkg::*;

    // Registers written over APB.
    logic [9:0]  line_control_reg_r,    line_control_reg_nxt;
    logic [2:0]  display_control_reg_r, display_control_reg_nxt;
    logic [6:0]  last_common_row_r,     last_common_row_nxt;
    logic [6:0]  active_first_row_r,    active_first_row_nxt;
    logic [6:0]  active_last_row_r,     active_last_row_nxt;
    logic [6:0]  scroll_start_row_r,    scroll_start_row_nxt;
    logic [6:0]  fixed_region_rows_r,   fixed_region_rows_nxt;
    stndc_fmt_t  color_fmt_r,           color_fmt_nxt;

    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;
    logic        drivers_on;
    logic        force_all_on;
    logic        invert_pixels;

    assign wr_en         = psel && penable && pwrite;
    assign rd_en         = psel && penable && !pwrite;
    assign drivers_on    = display_control_reg_r[DC_DRV_BIT];
    assign force_all_on  = display_control_reg_r[DC_ALLON_BIT];
    assign invert_pixels = display_control_reg_r[DC_INV_BIT];
    assign pready        = 1'b1;

    always_comb begin
        addr_ok = 1'b1;
        unique case (paddr)
            OFS_LINE_CTRL, OFS_DISP_CTRL, OFS_LAST_COM, OFS_ACT_FIRST,
            OFS_ACT_LAST, OFS_SCROLL, OFS_FIXED, OFS_COLOR_FMT, OFS_STATUS: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !addr_ok;

    always_comb begin
        line_control_reg_nxt    = line_control_reg_r;
        display_control_reg_nxt = display_control_reg_r;
        last_common_row_nxt     = last_common_row_r;
        active_first_row_nxt    = active_first_row_r;
        active_last_row_nxt     = active_last_row_r;
        scroll_start_row_nxt    = scroll_start_row_r;
        fixed_region_rows_nxt   = fixed_region_rows_r;
        color_fmt_nxt           = color_fmt_r;
        if (wr_en) begin
            unique case (paddr)
                OFS_LINE_CTRL: line_control_reg_nxt    = pwdata[9:0];
                OFS_DISP_CTRL: display_control_reg_nxt = pwdata[2:0];
                OFS_LAST_COM:  last_common_row_nxt     = pwdata[6:0];
                OFS_ACT_FIRST: active_first_row_nxt    = pwdata[6:0];
                OFS_ACT_LAST:  active_last_row_nxt     = pwdata[6:0];
                OFS_SCROLL:    scroll_start_row_nxt    = pwdata[6:0];
                OFS_FIXED:     fixed_region_rows_nxt   = pwdata[6:0];
                OFS_COLOR_FMT: color_fmt_nxt           = stndc_fmt_t'(pwdata[1:0]);
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_control_reg_r    <= LC_RST;
            display_control_reg_r <= DC_RST;
            last_common_row_r     <= LAST_COM_RST;
            active_first_row_r    <= ACT_FIRST_RST;
            active_last_row_r     <= ACT_LAST_RST;
            scroll_start_row_r    <= ROWREG_RST;
            fixed_region_rows_r   <= ROWREG_RST;
            color_fmt_r           <= FMT_RST;
        end else begin
            line_control_reg_r    <= line_control_reg_nxt;
            display_control_reg_r <= display_control_reg_nxt;
            last_common_row_r     <= last_common_row_nxt;
            active_first_row_r    <= active_first_row_nxt;
            active_last_row_r     <= active_last_row_nxt;
            scroll_start_row_r    <= scroll_start_row_nxt;
            fixed_region_rows_r   <= fixed_region_rows_nxt;
            color_fmt_r           <= color_fmt_nxt;
        end
    end

    // Scan geometry.
    logic       part_en;
    logic       part_onoff;
    logic [6:0] cen_c;
    logic [6:0] scan_first;
    logic [6:0] scan_last;
    logic [7:0] mux_rate;
    logic [10:0] base_cyc;

    assign part_en    = line_control_reg_r[LC_PART_BIT];
    assign part_onoff = part_en && line_control_reg_r[LC_ONOFF_BIT];
    assign cen_c      = (last_common_row_r > ROWS_LAST) ? ROWS_LAST : last_common_row_r;
    assign scan_first = part_onoff ? active_first_row_r : 7'h00;
    assign scan_last  = part_onoff ? active_last_row_r : cen_c;
    assign mux_rate   = 8'({1'b0, scan_last} - {1'b0, scan_first}) + 8'h01;

    always_comb begin
        unique case (line_control_reg_r[LC_RATE_LSB +: 2])
            2'b00: base_cyc = LINE0_CYC;
            2'b01: base_cyc = LINE1_CYC;
            2'b10: base_cyc = LINE2_CYC;
            2'b11: base_cyc = LINE3_CYC;
        endcase
    end

    // Line period as it would be if latched now.
    logic [12:0] slow_cyc;
    logic [16:0] sh8_prod;
    logic [13:0] per_calc;

    always_comb begin
        if (mux_rate <= MUX_THIRD) begin
            slow_cyc = 13'(base_cyc) * 13'h0003;
        end else if (mux_rate <= MUX_HALF) begin
            slow_cyc = 13'(base_cyc) * 13'h0002;
        end else begin
            slow_cyc = 13'(base_cyc);
        end
        sh8_prod = 17'(slow_cyc) * 17'(SH8_NUM);
        if (line_control_reg_r[LC_SHADE8_BIT]) begin
            per_calc = 14'(sh8_prod / 17'(SH8_DEN));
        end else begin
            per_calc = 14'(slow_cyc);
        end
    end

    // Timing generator: period and modulation are only taken at frame ends.
    logic [13:0] per_r,      per_nxt;
    logic [13:0] line_cnt_r, line_cnt_nxt;
    logic [6:0]  row_r,      row_nxt;
    logic        shade8_r,   shade8_nxt;
    logic        line_tick;
    logic        frame_tick;

    assign line_tick  = (line_cnt_r >= per_r - 14'h0001);
    assign frame_tick = line_tick && (row_r >= scan_last || row_r < scan_first);

    always_comb begin
        per_nxt      = per_r;
        shade8_nxt   = shade8_r;
        row_nxt      = row_r;
        line_cnt_nxt = line_tick ? 14'h0000 : line_cnt_r + 14'h0001;
        if (frame_tick) begin
            per_nxt    = per_calc;
            shade8_nxt = line_control_reg_r[LC_SHADE8_BIT];
            row_nxt    = scan_first;
        end else if (line_tick) begin
            row_nxt = row_r + 7'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_r      <= 14'(LINE0_CYC);
            line_cnt_r <= 14'h0000;
            row_r      <= 7'h00;
            shade8_r   <= 1'b0;
        end else begin
            per_r      <= per_nxt;
            line_cnt_r <= line_cnt_nxt;
            row_r      <= row_nxt;
            shade8_r   <= shade8_nxt;
        end
    end

    // Power sequencer.
    stndc_pwr_t  pwr_r,  pwr_nxt;
    logic [19:0] pcnt_r, pcnt_nxt;

    always_comb begin
        pwr_nxt  = pwr_r;
        pcnt_nxt = pcnt_r + 20'h00001;
        if (!drivers_on) begin
            pwr_nxt  = PWR_SLEEP;
            pcnt_nxt = 20'h00000;
        end else begin
            unique case (pwr_r)
                PWR_SLEEP: begin
                    pwr_nxt  = PWR_WAKE;
                    pcnt_nxt = 20'h00000;
                end
                PWR_WAKE: begin
                    if (pcnt_r >= 20'(WAKE_CYC - 1)) begin
                        pwr_nxt  = PWR_RAILS;
                        pcnt_nxt = 20'h00000;
                    end
                end
                PWR_RAILS: begin
                    if (pcnt_r >= 20'(RAIL_CYC - 1)) begin
                        pwr_nxt  = PWR_ACTIVE;
                        pcnt_nxt = 20'h00000;
                    end
                end
                PWR_ACTIVE: pcnt_nxt = 20'h00000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_r  <= PWR_SLEEP;
            pcnt_r <= 20'h00000;
        end else begin
            pwr_r  <= pwr_nxt;
            pcnt_r <= pcnt_nxt;
        end
    end

    logic drv_act;
    // Gating with the enable itself lets COM and SEG drop on the first edge after the flag clears.
    assign drv_act      = (pwr_r == PWR_ACTIVE) && drivers_on;
    assign lcd_sleep    = (pwr_r == PWR_SLEEP);
    assign lcd_rails_on = (pwr_r == PWR_RAILS) || drv_act;

    // RAM row for the scanned COM: the fixed band at the top never scrolls.
    logic [7:0] scroll_sum;
    logic [7:0] span;
    always_comb begin
        span       = 8'(NUM_COM) - {1'b0, fixed_region_rows_r};
        scroll_sum = {1'b0, row_r} + {1'b0, scroll_start_row_r};
        if (row_r < fixed_region_rows_r) begin
            ram_rd_row = row_r;
        end else if (scroll_sum >= 8'(NUM_COM)) begin
            ram_rd_row = 7'(scroll_sum - span);
        end else begin
            ram_rd_row = 7'(scroll_sum);
        end
    end

    // Panel outputs, all from flip-flops.
    logic [NUM_COM-1:0] com_r,   com_nxt;
    logic [SEG_W-1:0]   seg_r,   seg_nxt;
    logic               short_r, short_nxt;
    logic               fst_r,   fst_nxt;
    logic               win_hit;

    assign win_hit = !part_en || part_onoff ||
                     (row_r >= active_first_row_r && row_r <= active_last_row_r);

    always_comb begin
        com_nxt = '0;
        for (int x = 0; x < NUM_COM; x++) begin
            com_nxt[x] = drv_act && win_hit && (7'(x) == row_r);
        end
        fst_nxt   = frame_tick;
        short_nxt = !drv_act;
        if (!drv_act) begin
            seg_nxt = '0;
        end else if (force_all_on) begin
            seg_nxt = '1;
        end else if (invert_pixels) begin
            seg_nxt = ~ram_rd_data;
        end else begin
            seg_nxt = ram_rd_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            com_r   <= '0;
            seg_r   <= '0;
            short_r <= 1'b1;
            fst_r   <= 1'b0;
        end else begin
            com_r   <= com_nxt;
            seg_r   <= seg_nxt;
            short_r <= short_nxt;
            fst_r   <= fst_nxt;
        end
    end

    assign com_drive     = com_r;
    assign seg_out       = seg_r;
    assign seg_short     = short_r;
    assign frame_start   = fst_r;
    assign shade8_active = shade8_r;

    // Color conversion. A 2x2 ordered threshold keeps it repeatable per position.
    function automatic logic [4:0] dq(input logic [7:0] v, input int n, input logic [1:0] d);
        logic [7:0] q;
        logic [7:0] f;
        logic [7:0] top;
        q   = v >> (8 - n);
        f   = (v << n) >> 6;
        top = (8'h01 << n) - 8'h01;
        if (f[1:0] > d && q != top) begin
            q = q + 8'h01;
        end
        return q[4:0];
    endfunction

    logic [1:0]  dth;
    logic [11:0] conv;
    logic [11:0] wd_r, wd_nxt;
    logic        wv_r, wv_nxt;
    logic [7:0]  r8, g8, b8;
    logic [4:0]  qr, qg, qb;

    assign dth       = {pix_row[0] ^ pix_col[0], pix_col[0]};
    assign pix_ready = ram_wr_ready || !wv_r;

    // Components are scaled to eight bits so one dither routine serves the 12-, 16- and 24-bit formats.
    always_comb begin
        r8 = pix_data[23:16];
        g8 = pix_data[15:8];
        b8 = pix_data[7:0];
        if (color_fmt_r == FMT_16BIT) begin
            r8 = {pix_data[15:11], 3'h0};
            g8 = {pix_data[10:5], 2'h0};
            b8 = {pix_data[4:0], 3'h0};
        end else if (color_fmt_r == FMT_12BIT) begin
            b8 = {pix_data[3:0], 4'h0};
        end
    end

    assign qr = dq(r8, 4, dth);
    assign qg = dq(g8, 5, dth);
    assign qb = dq(b8, 3, dth);

    always_comb begin
        unique case (color_fmt_r)
            FMT_8BIT: conv = {pix_data[7:5], pix_data[7], pix_data[4:2], pix_data[4:3],
                              pix_data[1:0], pix_data[1]};
            FMT_12BIT: conv = {pix_data[11:8], pix_data[7:4], pix_data[7], qb[2:0]};
            FMT_16BIT: conv = {qr[3:0], qg, qb[2:0]};
            FMT_24BIT: conv = {qr[3:0], qg, qb[2:0]};
        endcase
        wv_nxt = wv_r && !ram_wr_ready;
        wd_nxt = wd_r;
        if (pix_valid && pix_ready) begin
            wv_nxt = 1'b1;
            wd_nxt = conv;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wv_r <= 1'b0;
            wd_r <= 12'h000;
        end else begin
            wv_r <= wv_nxt;
            wd_r <= wd_nxt;
        end
    end

    assign ram_wr_valid = wv_r;
    assign ram_wr_data  = wd_r;

    // Read data.
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_en) begin
            unique case (paddr)
                OFS_LINE_CTRL: prdata = {22'h0, line_control_reg_r};
                OFS_DISP_CTRL: prdata = {29'h0, display_control_reg_r};
                OFS_LAST_COM:  prdata = {25'h0, last_common_row_r};
                OFS_ACT_FIRST: prdata = {25'h0, active_first_row_r};
                OFS_ACT_LAST:  prdata = {25'h0, active_last_row_r};
                OFS_SCROLL:    prdata = {25'h0, scroll_start_row_r};
                OFS_FIXED:     prdata = {25'h0, fixed_region_rows_r};
                OFS_COLOR_FMT: prdata = {30'h0, color_fmt_r};
                OFS_STATUS:    prdata = {13'h0, shade8_r, pwr_r, 9'h0, row_r};
                default:       prdata = 32'h0000_0000;
            endcase
        end
    end

    // Checks.
    AST_IDLE_SHORT: assert property (@(posedge pclk) disable iff (!presetn)
        !drv_act |=> seg_short && seg_out == '0)
        else $error("Idle segments not shorted.");
    AST_ALLON: assert property (@(posedge pclk) disable iff (!presetn)
        drv_act && force_all_on |=> seg_out == '1)
        else $error("Force-all-on did not drive ON.");
    AST_INVERT: assert property (@(posedge pclk) disable iff (!presetn)
        drv_act && !force_all_on && invert_pixels |=> seg_out == ~$past(ram_rd_data))
        else $error("Inverse output wrong.");
    AST_OFF_SLEEP: assert property (@(posedge pclk) disable iff (!presetn)
        !drivers_on |=> lcd_sleep && com_drive == '0)
        else $error("Drivers not idle after disable.");
    AST_WAKE_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
        lcd_sleep && drivers_on |=> !lcd_sleep && !lcd_rails_on && com_drive == '0)
        else $error("Power-up order wrong.");
    AST_COM_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot0(com_drive))
        else $error("More than one COM active.");
    AST_FRAME_ROW: assert property (@(posedge pclk) disable iff (!presetn)
        frame_tick |=> row_r == $past(scan_first))
        else $error("Frame did not restart at first row.");
    AST_THIRD: assert property (@(posedge pclk) disable iff (!presetn)
        frame_tick && mux_rate <= MUX_THIRD && !line_control_reg_r[LC_SHADE8_BIT]
        |=> per_r == 14'($past(base_cyc)) * 14'h0003)
        else $error("Low mux slowdown wrong.");
    AST_HOLD_PER: assert property (@(posedge pclk) disable iff (!presetn)
        !frame_tick |=> $stable(per_r) && $stable(shade8_r))
        else $error("Timing changed mid-frame.");
endmodule : stndc_top
`default_nettype wire

// File: verification/stndc_panel_model.sv
// Purpose: Display RAM stand-in on the panel side of the scan and write ports.
// Assumes: One SEG_W word a row; converted pixels are always accepted.
// Notes:   Row data is never all ones or all zeros, so inversion shows.
`timescale 1ns/100ps
`default_nettype none
module stndc_panel_model (
    // Scan read
    input  wire logic [6:0]  ram_rd_row,
    output logic      [11:0] ram_rd_data,
    // Write port
    output logic             ram_wr_ready
);
    assign ram_rd_data  = {5'h15, ram_rd_row};
    assign ram_wr_ready = 1'b1;
endmodule : stndc_panel_model
`default_nettype wire

// File: verification/tb.sv
// Purpose: Self-checking bench for the STN display control block.
// Assumes: APB master tasks; rail settle time shortened to 20 cycles.
// Notes:   Pixel checks use all-ones and all-zero inputs of each format, then one 24-bit gray at two dither columns.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import stndc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic        pix_valid, pix_ready, ram_wr_valid, ram_wr_ready;
    logic        seg_short, lcd_sleep, lcd_rails_on, frame_start, shade8_active;
    logic [11:0] paddr, ram_wr_data, ram_rd_data, seg_out;
    logic [31:0] pwdata, prdata, q;
    logic [23:0] pix_data;
    logic [6:0]  ram_rd_row, pix_col, pix_row;
    logic [79:0] com_drive, p;
    int          num_errors, comparisons, cyc, n;

    stndc_top #(.RAIL_CYC(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pix_valid(pix_valid), .pix_ready(pix_ready),
        .pix_data(pix_data), .pix_col(pix_col), .pix_row(pix_row), .ram_wr_valid(ram_wr_valid),
        .ram_wr_ready(ram_wr_ready), .ram_wr_data(ram_wr_data), .ram_rd_row(ram_rd_row),
        .ram_rd_data(ram_rd_data), .com_drive(com_drive), .seg_out(seg_out),
        .seg_short(seg_short), .shade8_active(shade8_active), .frame_start(frame_start),
        .lcd_sleep(lcd_sleep), .lcd_rails_on(lcd_rails_on));
    stndc_panel_model panel (.ram_rd_row(ram_rd_row), .ram_rd_data(ram_rd_data),
        .ram_wr_ready(ram_wr_ready));

    always #12.5 pclk = ~pclk;

    task automatic stop_test;
        if (num_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Entered just after a rising edge; returns one edge after the edge that completes it.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Sends one pixel and checks the converted word on the following cycle.
    task automatic pix(input logic [23:0] d, input logic [11:0] exp);
        pix_valid <= 1'b1;
        pix_data <= d;
        @(posedge pclk);
        while (pix_ready !== 1'b1) @(posedge pclk);
        pix_valid <= 1'b0;
        @(negedge pclk);
        chk({ram_wr_valid, 19'h0, ram_wr_data}, {1'b1, 19'h0, exp});
        @(posedge pclk);
    endtask : pix

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            stop_test();
        end
    end

    initial begin
        {pclk, presetn, psel, penable, pwrite, pix_valid} = 6'h00;
        {paddr, pwdata, pix_data, pix_col, pix_row, num_errors, comparisons, cyc} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFS_COLOR_FMT, 32'h0);
        chk(q, 32'(FMT_16BIT));
        apb(1'b0, 12'h024, 32'h0);
        chk({e, q[30:0]}, 32'h80000000);
        chk(32'({lcd_sleep, lcd_rails_on, seg_short}), 32'h5);
        apb(1'b1, OFS_DISP_CTRL, 32'h2);
        repeat (3) @(posedge pclk);
        chk(32'(seg_out), 32'h0);
        apb(1'b1, OFS_DISP_CTRL, 32'h4);
        repeat (2) @(negedge pclk);
        chk(32'({lcd_sleep, lcd_rails_on, seg_short}), 32'h1);
        repeat (50) @(negedge pclk);
        chk(32'({lcd_sleep, lcd_rails_on, seg_short}), 32'h3);
        repeat (30) @(negedge pclk);
        chk(32'({lcd_sleep, lcd_rails_on, seg_short}), 32'h2);
        p = com_drive;
        while (com_drive === p) @(negedge pclk);
        p = com_drive;
        n = 0;
        while (com_drive === p) begin
            @(negedge pclk);
            n++;
        end
        chk(32'(n), 32'(LINE0_CYC));
        chk($countones(com_drive), 32'h1);
        @(posedge pclk);
        apb(1'b1, OFS_DISP_CTRL, 32'h6);
        repeat (3) @(posedge pclk);
        chk(32'(seg_out), 32'hfff);
        apb(1'b1, OFS_DISP_CTRL, 32'h5);
        repeat (3) @(posedge pclk);
        chk(32'(seg_out), {20'h0, ~ram_rd_data});
        apb(1'b1, OFS_DISP_CTRL, 32'h0);
        repeat (3) @(posedge pclk);
        chk(32'({lcd_sleep, seg_short}), 32'h3);
        for (int f = 0; f < 4; f++) begin
            apb(1'b1, OFS_COLOR_FMT, 32'(f));
            pix(24'((64'h1 << (8 + 4 * f + (f == 3 ? 4 : 0))) - 1), 12'hfff);
            pix(24'h0, 12'h000);
        end
        pix(24'h181818, 12'h219);
        pix_col <= 7'h01;
        pix(24'h181818, 12'h118);
        apb(1'b1, OFS_ACT_LAST, 32'h0);
        apb(1'b1, OFS_LINE_CTRL, 32'h318);
        for (int k = 0; k < 4; k++) begin
            if (k == 2) begin
                @(posedge pclk);
                apb(1'b1, OFS_LINE_CTRL, 32'h338);
            end
            n = 0;
            do begin
                @(negedge pclk);
                n++;
            end while (frame_start !== 1'b1);
            if (k == 1) chk(32'(n), 32'(3 * LINE3_CYC));
            if (k == 3) chk(32'(n), 32'(3 * LINE3_CYC * SH8_NUM / SH8_DEN));
        end
        chk(32'(shade8_active), 32'h1);
        stop_test();
    end
endmodule : tb
`default_nettype wire
